// File: ecrb_consts.svh
// Constants of the engine configuration register bank: frame layout,
// command codes, register offsets, writable-bit masks and reset values.
// Assumes inclusion by bare name from the package and the design module.
`ifndef ECRB_CONSTS_SVH
`define ECRB_CONSTS_SVH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define ECRB_FRAME_BITS   16
`define ECRB_CMD_MSB      15
`define ECRB_CMD_LSB      12
`define ECRB_ADDR_MSB     11
`define ECRB_ADDR_LSB     8
`define ECRB_NUM_REGS     14

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define ECRB_CMD_CHECK    4'h0
`define ECRB_CMD_RD_CFG   4'h1
`define ECRB_CMD_WR_CFG   4'h2
`define ECRB_CMD_RD_STS   4'h3
`define ECRB_CMD_WR_STS   4'h4
`define ECRB_CMD_RD_CTL   4'h5
`define ECRB_CMD_WR_CTL   4'h6
`define ECRB_CMD_CHK_RSP  4'h7

// ----------------------------------------------------------------------
// Configuration register offsets
// ----------------------------------------------------------------------
`define ECRB_INJECTOR_ONE_SETUP   4'h0
`define ECRB_INJECTOR_TWO_SETUP   4'h1
`define ECRB_RELAY_ONE_SETUP      4'h2
`define ECRB_RELAY_TWO_SETUP      4'h3
`define ECRB_TACH_OUTPUT_SETUP    4'h4
`define ECRB_LAMP_SETUP           4'h5
`define ECRB_BATTERY_SWITCH_SETUP 4'h6
`define ECRB_HEATER_PREDRV_SETUP  4'h7
`define ECRB_IGNITION_ONE_SETUP   4'h8
`define ECRB_IGNITION_TWO_SETUP   4'h9
`define ECRB_WATCHDOG_SETUP       4'ha
`define ECRB_SENSOR_MANUAL_SETUP  4'hb
`define ECRB_SENSOR_AUTO_SETUP    4'hc
`define ECRB_SENSOR_MISC_SETUP    4'hd

// ----------------------------------------------------------------------
// Configuration masks (existing bits) and reset values
// ----------------------------------------------------------------------
`define ECRB_MSK_DRIVER   8'h9f
`define ECRB_MSK_RELAY2   8'hdf
`define ECRB_MSK_LAMP     8'h9b
`define ECRB_MSK_BATSW    8'h83
`define ECRB_MSK_PREDRV   8'hd7
`define ECRB_MSK_FULL     8'hff
`define ECRB_MSK_MISC     8'hdf
`define ECRB_RST_INJ      8'h10
`define ECRB_RST_RELAY1   8'h18
`define ECRB_RST_RELAY2   8'h10
`define ECRB_RST_TACH     8'h01
`define ECRB_RST_LAMP     8'h18
`define ECRB_RST_BATSW    8'h00
`define ECRB_RST_HEATER   8'h10
`define ECRB_RST_IGN      8'h80
`define ECRB_RST_WDOG     8'hca
`define ECRB_RST_MANUAL   8'h53
`define ECRB_RST_AUTO     8'h21
`define ECRB_RST_MISC     8'h00

// ----------------------------------------------------------------------
// Control registers: masks and reset values
// ----------------------------------------------------------------------
`define ECRB_CTL_MAIN     4'h0
`define ECRB_CTL_OTHER    4'h1
`define ECRB_CTL_WDOG     4'hc
`define ECRB_CTL_SENSOR   4'hd
`define ECRB_CMSK_OTHER   8'hd7
`define ECRB_CMSK_PWM     8'h7f
`define ECRB_CRST_OTHER   8'h12
`define ECRB_CRST_ZERO    8'h00

`endif

// File: ecrb_pkg.sv
// Types shared by the engine configuration register bank.
// Assumes the constants header sits in the same folder.
package ecrb_pkg;
    `include "ecrb_consts.svh"
    typedef logic [7:0]  ecrb_byte_t;
    typedef logic [3:0]  ecrb_nib_t;
    typedef logic [15:0] ecrb_word_t;
endpackage

// File: ecrb_regbank.sv
// Engine configuration, control and status register bank behind a
// four-wire serial port. Assumes the host keeps chip_select_n high for
// at least eight clock cycles between frames and sclk idle while high.
`timescale 1ns/1ps
`include "ecrb_consts.svh"

// Notes on behaviour
// [RULE_01] Serial parameters live in 8-bit registers the host can read and write.
// [RULE_02] Configuration, control and status banks each have own read/write codes.
// [RULE_03] Control registers carry on/off bits and per-output duty values.
// [RULE_04] Status registers report fault and other block conditions to host.
// [RULE_05] Any reset returns every configuration bit to its default value.
// [RULE_06] Driver setups: retry, open-load sink, in-rush, combine, two-bit frequency.
// [RULE_07] Second relay setup adds shutdown disable in bit 6, default zero.
// [RULE_08] Tach setup: retry, source select, mode, divider bits default divide-by-1.
// [RULE_09] Battery switch setup: high-side mode bit 7, frequency bits 1..0 only.
// [RULE_10] Pre-driver setups: gate select, retry, sink, combine, frequency bits.
// [RULE_11] Watchdog setup: enable bit 7 set by default, weighted load time.
// [RULE_12] Sensor manual setup: threshold code high nibble, filter code low.
// [RULE_13] Sensor auto setup: mantissa high nibble, exponent low nibble.
// [RULE_14] Sensor misc setup: seven option bits, bit 5 absent, all default zero.
// [RULE_15] Absent bits always read zero; writes to them do nothing.
// [RULE_16] Frame is 16 bits: command nibble, address nibble, data byte.
// [RULE_17] Read data returns in the following frame.
// [RULE_18] Commands act only at the rising edge of chip select.
// [RULE_19] Configuration addresses 0xE and 0xF read zero and ignore writes.
module ecrb_regbank
    import ecrb_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic       sclk,
    input  wire logic       chip_select_n,
    input  wire logic       mosi,
    output logic            miso_q,
    input  wire ecrb_byte_t sts_set [`ECRB_NUM_REGS],
    output ecrb_byte_t      cfg_q   [`ECRB_NUM_REGS],
    output ecrb_byte_t      ctl_q   [`ECRB_NUM_REGS],
    output ecrb_byte_t      sts_q   [`ECRB_NUM_REGS]
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic ecrb_byte_t cfg_mask(input ecrb_nib_t a);
        case (a)
            `ECRB_INJECTOR_ONE_SETUP,
            `ECRB_INJECTOR_TWO_SETUP,
            `ECRB_RELAY_ONE_SETUP:      cfg_mask = `ECRB_MSK_DRIVER; // [RULE_06]
            `ECRB_RELAY_TWO_SETUP:      cfg_mask = `ECRB_MSK_RELAY2; // [RULE_07]
            `ECRB_TACH_OUTPUT_SETUP:    cfg_mask = `ECRB_MSK_FULL;   // [RULE_08]
            `ECRB_LAMP_SETUP:           cfg_mask = `ECRB_MSK_LAMP;   // [RULE_06]
            `ECRB_BATTERY_SWITCH_SETUP: cfg_mask = `ECRB_MSK_BATSW;  // [RULE_09]
            `ECRB_HEATER_PREDRV_SETUP,
            `ECRB_IGNITION_ONE_SETUP,
            `ECRB_IGNITION_TWO_SETUP:   cfg_mask = `ECRB_MSK_PREDRV; // [RULE_10]
            `ECRB_WATCHDOG_SETUP,                                    // [RULE_11]
            `ECRB_SENSOR_MANUAL_SETUP,                               // [RULE_12]
            `ECRB_SENSOR_AUTO_SETUP:    cfg_mask = `ECRB_MSK_FULL;   // [RULE_13]
            `ECRB_SENSOR_MISC_SETUP:    cfg_mask = `ECRB_MSK_MISC;   // [RULE_14]
            default:                    cfg_mask = 8'h00;            // [RULE_19]
        endcase
    endfunction

    function automatic ecrb_byte_t cfg_reset(input ecrb_nib_t a);
        case (a)
            `ECRB_INJECTOR_ONE_SETUP,
            `ECRB_INJECTOR_TWO_SETUP:   cfg_reset = `ECRB_RST_INJ;
            `ECRB_RELAY_ONE_SETUP:      cfg_reset = `ECRB_RST_RELAY1;
            `ECRB_RELAY_TWO_SETUP:      cfg_reset = `ECRB_RST_RELAY2;
            `ECRB_TACH_OUTPUT_SETUP:    cfg_reset = `ECRB_RST_TACH;
            `ECRB_LAMP_SETUP:           cfg_reset = `ECRB_RST_LAMP;
            `ECRB_BATTERY_SWITCH_SETUP: cfg_reset = `ECRB_RST_BATSW;
            `ECRB_HEATER_PREDRV_SETUP:  cfg_reset = `ECRB_RST_HEATER;
            `ECRB_IGNITION_ONE_SETUP,
            `ECRB_IGNITION_TWO_SETUP:   cfg_reset = `ECRB_RST_IGN;
            `ECRB_WATCHDOG_SETUP:       cfg_reset = `ECRB_RST_WDOG;
            `ECRB_SENSOR_MANUAL_SETUP:  cfg_reset = `ECRB_RST_MANUAL;
            `ECRB_SENSOR_AUTO_SETUP:    cfg_reset = `ECRB_RST_AUTO;
            default:                    cfg_reset = `ECRB_RST_MISC;
        endcase
    endfunction

    function automatic ecrb_byte_t ctl_mask(input ecrb_nib_t a);
        case (a)
            `ECRB_CTL_MAIN,
            `ECRB_CTL_WDOG,
            `ECRB_CTL_SENSOR: ctl_mask = `ECRB_MSK_FULL;
            `ECRB_CTL_OTHER:  ctl_mask = `ECRB_CMSK_OTHER;
            4'he, 4'hf:       ctl_mask = 8'h00;
            default:          ctl_mask = `ECRB_CMSK_PWM;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Link domain: shift in on rising sclk, drive out on rising sclk
    // ------------------------------------------------------------------
    ecrb_word_t rx_q;
    ecrb_nib_t  bit_cnt_q;
    ecrb_word_t tx_word_q;

    // Keeps only the last sixteen bits; a long frame keeps its tail
    always_ff @(posedge sclk) begin
        if (!chip_select_n) begin
            rx_q <= {rx_q[14:0], mosi};                       // [RULE_16]
        end
    end

    // Cleared while deselected so each frame starts at bit 15
    always_ff @(posedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_q <= 4'h0;
        end else begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
        end
    end

    // Host samples on falling sclk; tx_word_q is quiet during frames
    always_ff @(posedge sclk or posedge chip_select_n) begin
        if (chip_select_n) begin
            miso_q <= 1'b0;
        end else begin
            miso_q <= tx_word_q[~bit_cnt_q];                  // [RULE_17]
        end
    end

    // ------------------------------------------------------------------
    // Frame end detection in the system domain
    // ------------------------------------------------------------------
    logic cs_s1_q;
    logic cs_s2_q;
    logic cs_s3_q;
    logic frame_end;

    always_ff @(posedge clock) begin
        if (rst) begin
            cs_s1_q <= 1'b1;
            cs_s2_q <= 1'b1;
            cs_s3_q <= 1'b1;
        end else begin
            cs_s1_q <= chip_select_n;
            cs_s2_q <= cs_s1_q;
            cs_s3_q <= cs_s2_q;
        end
    end

    // rx_q is stable here: sclk idles once chip select has risen
    assign frame_end = cs_s2_q & ~cs_s3_q;                    // [RULE_18]

    ecrb_nib_t  cmd;
    ecrb_nib_t  addr;
    ecrb_byte_t wdata;
    logic       addr_ok;

    assign cmd     = rx_q[`ECRB_CMD_MSB:`ECRB_CMD_LSB];       // [RULE_16]
    assign addr    = rx_q[`ECRB_ADDR_MSB:`ECRB_ADDR_LSB];
    assign wdata   = rx_q[7:0];
    assign addr_ok = (addr < 4'(`ECRB_NUM_REGS));             // [RULE_19]

    // ------------------------------------------------------------------
    // Register banks
    // ------------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `ECRB_NUM_REGS; gi++) begin : g_reg
            logic hit;
            assign hit = frame_end && (addr == 4'(gi));

            always_ff @(posedge clock) begin
                if (rst) begin
                    cfg_q[gi] <= cfg_reset(4'(gi));           // [RULE_05]
                end else if (hit && cmd == `ECRB_CMD_WR_CFG) begin
                    cfg_q[gi] <= wdata & cfg_mask(4'(gi));    // [RULE_15]
                end
            end

            always_ff @(posedge clock) begin
                if (rst) begin
                    ctl_q[gi] <= (gi == 1) ? `ECRB_CRST_OTHER
                                           : `ECRB_CRST_ZERO;
                end else if (hit && cmd == `ECRB_CMD_WR_CTL) begin
                    ctl_q[gi] <= wdata & ctl_mask(4'(gi));    // [RULE_03]
                end
            end

            // Hardware set wins over a host clear in the same cycle
            always_ff @(posedge clock) begin
                if (rst) begin
                    sts_q[gi] <= 8'h00;
                end else if (hit && cmd == `ECRB_CMD_WR_STS) begin
                    sts_q[gi] <= (sts_q[gi] & wdata) | sts_set[gi];
                end else begin
                    sts_q[gi] <= sts_q[gi] | sts_set[gi];     // [RULE_04]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Response word for the next frame
    // ------------------------------------------------------------------
    ecrb_byte_t rd_byte;

    always_comb begin
        rd_byte = 8'h00;
        if (addr_ok) begin
            case (cmd)
                `ECRB_CMD_RD_CFG: rd_byte = cfg_q[addr];      // [RULE_01]
                `ECRB_CMD_RD_STS: rd_byte = sts_q[addr];
                `ECRB_CMD_RD_CTL: rd_byte = ctl_q[addr];
                default:          rd_byte = wdata;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            tx_word_q <= 16'h0000;
        end else if (frame_end) begin
            case (cmd)                                        // [RULE_02]
                `ECRB_CMD_CHECK:
                    tx_word_q <= {`ECRB_CMD_CHK_RSP, rx_q[11:0]};
                `ECRB_CMD_RD_CFG, `ECRB_CMD_RD_STS, `ECRB_CMD_RD_CTL,
                `ECRB_CMD_WR_CFG, `ECRB_CMD_WR_STS, `ECRB_CMD_WR_CTL:
                    tx_word_q <= {cmd, addr, rd_byte};        // [RULE_17]
                default:
                    tx_word_q <= 16'h0000;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic       h_evt_q;
    ecrb_word_t h_word_q;

    always_ff @(posedge clock) begin
        if (rst) begin
            h_evt_q  <= 1'b0;
            h_word_q <= 16'h0000;
        end else begin
            h_evt_q  <= frame_end;
            h_word_q <= rx_q;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_cfg_write_lands: assert property ( // [RULE_06]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_WR_CFG
        && h_word_q[11:8] < 4'(`ECRB_NUM_REGS)
        |-> cfg_q[h_word_q[11:8]]
            == (h_word_q[7:0] & cfg_mask(h_word_q[11:8])))
        else $error("configuration write not stored");

    a_ctl_write_lands: assert property ( // [RULE_03]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_WR_CTL
        && h_word_q[11:8] < 4'(`ECRB_NUM_REGS)
        |-> ctl_q[h_word_q[11:8]]
            == (h_word_q[7:0] & ctl_mask(h_word_q[11:8])))
        else $error("control write not stored");

    a_cfg_read_reply: assert property ( // [RULE_17]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_RD_CFG
        && h_word_q[11:8] < 4'(`ECRB_NUM_REGS)
        |-> tx_word_q == {h_word_q[15:8], cfg_q[h_word_q[11:8]]})
        else $error("read reply does not match register");

    a_unused_addr_zero: assert property ( // [RULE_19]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_RD_CFG
        && h_word_q[11:8] >= 4'(`ECRB_NUM_REGS)
        |-> tx_word_q[7:0] == 8'h00)
        else $error("unused address read not zero");

    a_check_echo: assert property ( // [RULE_02]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_CHECK
        |-> tx_word_q == {`ECRB_CMD_CHK_RSP, h_word_q[11:0]})
        else $error("check response wrong");

    a_absent_bits_zero: assert property ( // [RULE_15]
        cfg_q[6][6:2] == 5'h00 && cfg_q[13][5] == 1'b0
        && cfg_q[5][6:5] == 2'h0 && cfg_q[7][3] == 1'b0)
        else $error("absent configuration bit set");

    a_reset_defaults: assert property ( // [RULE_05]
        $past(rst) |-> cfg_q[10] == `ECRB_RST_WDOG
        && cfg_q[4] == `ECRB_RST_TACH && cfg_q[8] == `ECRB_RST_IGN
        && cfg_q[3] == `ECRB_RST_RELAY2)
        else $error("configuration default wrong after reset");

    a_only_at_frame: assert property ( // [RULE_18]
        !frame_end |=> $stable(cfg_q[3]) && $stable(ctl_q[0])
        && $stable(tx_word_q))
        else $error("register changed outside frame end");

    a_status_set_wins: assert property ( // [RULE_04]
        sts_set[0] != 8'h00
        |=> (sts_q[0] & $past(sts_set[0])) == $past(sts_set[0]))
        else $error("status event lost");

    // ------------------------------------------------------------------
    // Checks on defaults, decode and sticky status
    // ------------------------------------------------------------------
    a_ctl_absent_zero: assert property ( // [RULE_15]
        ctl_q[1][5] == 1'b0 && ctl_q[1][3] == 1'b0
        && ctl_q[2][7] == 1'b0 && ctl_q[11][7] == 1'b0)
        else $error("absent control bit set");

    a_reset_sensor: assert property ( // [RULE_05]
        $past(rst) |-> cfg_q[11] == `ECRB_RST_MANUAL
        && cfg_q[12] == `ECRB_RST_AUTO && cfg_q[13] == `ECRB_RST_MISC
        && cfg_q[0] == `ECRB_RST_INJ && cfg_q[7] == `ECRB_RST_HEATER)
        else $error("sensor or driver default wrong after reset");

    a_reset_control: assert property ( // [RULE_03]
        $past(rst) |-> ctl_q[1] == `ECRB_CRST_OTHER
        && ctl_q[0] == `ECRB_CRST_ZERO && sts_q[0] == 8'h00)
        else $error("control or status default wrong after reset");

    a_bad_cmd_quiet: assert property ( // [RULE_02]
        h_evt_q && h_word_q[15] |-> tx_word_q == 16'h0000)
        else $error("unknown command answered");

    a_write_echo: assert property ( // [RULE_17]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_WR_CFG
        && h_word_q[11:8] < 4'(`ECRB_NUM_REGS)
        |-> tx_word_q == h_word_q)
        else $error("write echo wrong");

    a_ctl_read_reply: assert property ( // [RULE_02]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_RD_CTL
        && h_word_q[11:8] < 4'(`ECRB_NUM_REGS)
        |-> tx_word_q == {h_word_q[15:8], ctl_q[h_word_q[11:8]]})
        else $error("control read reply wrong");

    // A check frame must leave cfg_q[10] and ctl_q[2] alone
    a_check_no_write: assert property ( // [RULE_02]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_CHECK
        |-> $stable(cfg_q[10]) && $stable(ctl_q[2]))
        else $error("check frame changed a register");

    a_unused_write_ignored: assert property ( // [RULE_19]
        h_evt_q && h_word_q[15:12] == `ECRB_CMD_WR_CFG
        && h_word_q[11:8] >= 4'(`ECRB_NUM_REGS)
        |-> $stable(cfg_q[0]) && $stable(cfg_q[13]))
        else $error("write to unused address landed");

    // Only a status write may drop a sticky bit
    a_sts_sticky: assert property ( // [RULE_04]
        !(frame_end && cmd == `ECRB_CMD_WR_STS)
        |=> (sts_q[4] & $past(sts_q[4])) == $past(sts_q[4]))
        else $error("status bit dropped without a write");

    c_cfg_write: cover property (
        frame_end && cmd == `ECRB_CMD_WR_CFG && addr_ok);
    c_cfg_read:  cover property (
        frame_end && cmd == `ECRB_CMD_RD_CFG && addr_ok);
    c_check:     cover property (frame_end && cmd == `ECRB_CMD_CHECK);
    c_sts_write: cover property (frame_end && cmd == `ECRB_CMD_WR_STS);
    c_set_clear: cover property (
        frame_end && cmd == `ECRB_CMD_WR_STS && sts_set[0] != 8'h00);

endmodule // ecrb_regbank

// File: ecrb_host_model.sv
// Host side serial master model for the configuration register bank.
// Assumes the bench calls xfer one frame at a time, never overlapping.
`timescale 1ns/1ps
module ecrb_host_model
    import ecrb_pkg::*;
(
    output logic      sclk,
    output logic      chip_select_n,
    output logic      mosi,
    input  wire logic miso_q
);
    // ------------------------------------------------------------------
    // Frame driver
    // ------------------------------------------------------------------
    localparam time HALF = 80ns;

    initial begin
        sclk = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    // Clock stands still between frames; odd offset keeps phase unrelated
    task automatic xfer(input ecrb_word_t tx, output ecrb_word_t rx);
        #1.3;
        chip_select_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mosi = tx[i];
            #HALF sclk = 1'b1;
            #HALF rx[i] = miso_q;
            sclk = 1'b0;
        end
        #HALF chip_select_n = 1'b1;
        // Deselected line must not keep showing the last bit
        mosi = ~mosi;
        // Gap of 50 clocks covers sync and update of the bank
        #200;
    endtask
endmodule // ecrb_host_model

// File: ecrb_regbank_tb.sv
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the serial pins and the bench the rest.
`timescale 1ns/1ps
`include "ecrb_consts.svh"
module ecrb_regbank_tb
    import ecrb_pkg::*;
;
    logic       clock;
    logic       rst;
    logic       sclk;
    logic       chip_select_n;
    logic       mosi;
    logic       miso_q;
    ecrb_byte_t sts_set [`ECRB_NUM_REGS];
    ecrb_byte_t cfg_q   [`ECRB_NUM_REGS];
    ecrb_byte_t ctl_q   [`ECRB_NUM_REGS];
    ecrb_byte_t sts_q   [`ECRB_NUM_REGS];
    int         num_errors = 0;
    int         comparisons = 0;

    localparam ecrb_byte_t DEF [14] = '{8'h10, 8'h10, 8'h18, 8'h10, 8'h01,
        8'h18, 8'h00, 8'h10, 8'h80, 8'h80, 8'hca, 8'h53, 8'h21, 8'h00};
    localparam ecrb_byte_t MSK [14] = '{8'h9f, 8'h9f, 8'h9f, 8'hdf, 8'hff,
        8'h9b, 8'h83, 8'hd7, 8'hd7, 8'hd7, 8'hff, 8'hff, 8'hff, 8'hdf};

    always #2 clock = ~clock;

    ecrb_regbank ecrb_regbank_inst (
        .clock         (clock),
        .rst           (rst),
        .sclk          (sclk),
        .chip_select_n (chip_select_n),
        .mosi          (mosi),
        .miso_q        (miso_q),
        .sts_set       (sts_set),
        .cfg_q         (cfg_q),
        .ctl_q         (ctl_q),
        .sts_q         (sts_q)
    );

    ecrb_host_model ecrb_host_model_inst (
        .sclk          (sclk),
        .chip_select_n (chip_select_n),
        .mosi          (mosi),
        .miso_q        (miso_q)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input ecrb_word_t got, input ecrb_word_t exp,
                       input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic xfer(input ecrb_word_t w, output ecrb_word_t r);
        ecrb_host_model_inst.xfer(w, r);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(posedge clock);
        rst <= 1'b1;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults();
        for (int i = 0; i < 14; i++) begin
            chk(cfg_q[i], DEF[i], "cfg default");
            chk(ctl_q[i], (i == 1) ? 8'h12 : 8'h00, "ctl reset");
            chk(sts_q[i], 8'h00, "sts default");
        end
        $display("test defaults done");
    endtask

    // All ones then all zeros; reads pipeline one frame behind
    task automatic t_masks();
        ecrb_word_t r;
        ecrb_byte_t e;
        for (int a = 0; a < 17; a++) begin
            if (a < 16) begin
                xfer({4'h2, a[3:0], 8'hff}, r);
            end else begin
                xfer(16'h0000, r);
            end
            if (a > 0) begin
                e = (a < 15) ? MSK[a-1] : 8'h00;
                chk(r, {4'h1, 4'(a - 1), e}, "read back");
            end
            if (a < 16) begin
                xfer({4'h1, a[3:0], 8'h00}, r);
            end
        end
        for (int i = 0; i < 14; i++) begin
            chk(cfg_q[i], MSK[i], "ones");
        end
        for (int a = 0; a < 16; a++) begin
            xfer({4'h2, a[3:0], 8'h00}, r);
        end
        for (int i = 0; i < 14; i++) begin
            chk(cfg_q[i], 8'h00, "zeros");
        end
        $display("test masks done");
    endtask

    task automatic t_cs_edge();
        ecrb_word_t r;
        fork
            xfer(16'h2a55, r);
            begin
                #2600;
                chk(cfg_q[10], 8'h00, "early act");
            end
        join
        chk(cfg_q[10], 8'h55, "late act");
        $display("test chip select done");
    endtask

    task automatic t_cmds();
        ecrb_word_t r;
        xfer(16'h0123, r);
        xfer(16'h8a77, r);
        chk(r, 16'h7123, "check reply");
        xfer(16'h0000, r);
        chk(r, 16'h0000, "unknown reply");
        chk(cfg_q[10], 8'h55, "unknown no write");
        xfer(16'h62ff, r);
        chk(ctl_q[2], 8'h7f, "ctl write");
        xfer(16'h5200, r);
        xfer(16'h0000, r);
        chk(r, 16'h527f, "ctl read");
        @(posedge clock);
        sts_set[4] <= 8'h0a;
        sts_set[0] <= 8'h01;
        @(posedge clock);
        sts_set[4] <= 8'h00;
        repeat (2) @(posedge clock);
        #1;
        chk(sts_q[4], 8'h0a, "sts sticky");
        xfer(16'h3400, r);
        xfer(16'h4400, r);
        chk(r, 16'h340a, "sts read");
        chk(sts_q[4], 8'h00, "sts clear");
        // Clear of register 0 lands while its event input is still high
        xfer(16'h4000, r);
        chk(sts_q[0], 8'h01, "set beats clear");
        @(posedge clock);
        sts_set[0] <= 8'h00;
        $display("test commands done");
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        foreach (sts_set[i]) sts_set[i] = 8'h00;
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        #1;
        t_defaults();
        t_masks();
        t_cs_edge();
        t_cmds();
        do_reset();
        t_defaults();
        summarize();
    end

    // Run needs about 170 us; limit stays under 100k clock cycles
    initial begin
        #300_000;
        num_errors++;
        $display("FAIL %0t watchdog expired", $time);
        summarize();
    end
endmodule // ecrb_regbank_tb
